// file: rtl/sleep_watchdog_ctrl.v
/*
 power-mode and watchdog controller: halt/stop sleep, wake paths, watchdog,
 flag side effects and the code-memory load lockout.
 assumes the decoder gives one-cycle opcode strobes and that all inputs are
 synchronous to clk_sys.
 assumes the decoder services interrupts itself and answers with irq_taken.
 assumes clk_sys keeps running in stop, so the wake pin can still be sampled;
 osc_en and cpu_clk_en tell the clock tree what to gate.
 assumes the supply monitor gives a clean level on low_supply_trip_level.
*/
`timescale 1ns/10ps
`include "sleep_wdog_map.vh"

module sleep_watchdog_ctrl #(
   parameter [`WDOG_CNT_W-1:0] WDOG_TIMEOUT = `WDOG_TIMEOUT_CYC
) (
   input wire clk_sys,
   input wire rstn,
   input wire op_valid,
   input wire [7:0] op_code,
   input wire code_mem_load_op,
   input wire code_mem_load_autoinc_op,
   input wire rom_protect,
   input wire irq_taken,
   input wire ext_irq_a,
   input wire ext_irq_b,
   input wire ext_irq_c,
   input wire ext_irq_d,
   input wire timer_irq_0,
   input wire timer_irq_1,
   input wire [7:0] port2_direction_reg,
   input wire stop_wake_pin,
   input wire low_supply_trip_level,
   output reg cpu_clk_en,
   output reg osc_en,
   output reg periph_clk_en,
   output reg irq_pending,
   output reg halted,
   output reg stopped,
   output reg sys_reset,
   output reg keep_port_modes,
   output reg pc_load,
   output reg [15:0] pc_load_addr,
   output reg flag_wr,
   output reg [7:0] flag_mask,
   output reg [7:0] flag_val,
   output reg load_refused,
   output reg wdog_enabled
);

   localparam [2:0] ST_RUN = 3'b001;
   localparam [2:0] ST_HALT = 3'b010;
   localparam [2:0] ST_STOP = 3'b100;

   reg [2:0] state_q;
   reg [2:0] state_d;
   reg wake_armed_q;
   reg wdog_en_q;
   reg wdog_halt_q;
   reg [`WDOG_CNT_W-1:0] wdog_cnt_q;
   reg [`RST_CNT_W-1:0] rst_cnt_q;
   reg rst_busy_q;
   wire any_irq;
   wire is_halt;
   wire is_stop;
   wire is_refresh;
   wire is_in_sleep;
   wire wdog_tick;
   wire wdog_expire;
   wire pin_wake;
   wire int_rst;
   wire in_reset;
   wire [2:0] state_nx;
   wire [`IRQ_SRC_N-1:0] irq_src;
   wire [`IRQ_SRC_N-1:0] irq_in_halt;
   reg wake_armed_d;
   reg wdog_en_d;
   reg wdog_halt_d;
   reg [`WDOG_CNT_W-1:0] wdog_cnt_d;
   reg [`RST_CNT_W-1:0] rst_cnt_d;
   reg rst_busy_d;
   reg cpu_clk_en_d;
   reg osc_en_d;
   reg periph_clk_en_d;
   reg irq_pending_d;
   reg halted_d;
   reg stopped_d;
   reg sys_reset_d;
   reg keep_port_modes_d;
   reg pc_load_d;
   reg [15:0] pc_load_addr_d;
   reg flag_wr_d;
   reg [7:0] flag_mask_d;
   reg [7:0] flag_val_d;
   reg load_refused_d;
   reg wdog_enabled_d;
   genvar gi;

   // request sources in a fixed order: four external inputs, then the two timers
   assign irq_src = {timer_irq_1, timer_irq_0, ext_irq_d, ext_irq_c, ext_irq_b, ext_irq_a};

   // each source stays live in halt and can wake the core on its own
   generate
      for (gi = 0; gi < `IRQ_SRC_N; gi = gi + 1) begin : g_irq
         assign irq_in_halt[gi] = state_q == ST_HALT && irq_src[gi];
      end
   endgenerate

   assign any_irq = |irq_in_halt;
   assign is_halt = op_valid && op_code == `OP_HALT && state_q == ST_RUN;
   assign is_stop = op_valid && op_code == `OP_STOP && state_q == ST_RUN;
   assign is_refresh = op_valid && op_code == `OP_WDOG_REFRESH;
   assign is_in_sleep = op_valid && op_code == `OP_WDOG_IN_SLEEP;
   assign pin_wake = state_q == ST_STOP && wake_armed_q && !stop_wake_pin;
   // counts in run, in halt only when allowed, never in stop
   assign wdog_tick = wdog_en_q && (state_q == ST_RUN || (state_q == ST_HALT && wdog_halt_q));
   assign wdog_expire = wdog_tick && wdog_cnt_q >= WDOG_TIMEOUT - 1'b1;
   assign int_rst = !rstn || low_supply_trip_level;
   assign in_reset = rst_busy_q || int_rst;
   // opcodes seen while reset is held must not move the visible state
   assign state_nx = in_reset ? ST_RUN : state_d;

   always @* begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (is_stop) begin
               state_d = ST_STOP;
            end else if (is_halt) begin
               state_d = ST_HALT;
            end
         end
         ST_HALT: begin
            if (irq_taken) begin
               state_d = ST_RUN;
            end
         end
         ST_STOP: begin
            if (pin_wake) begin
               state_d = ST_RUN;
            end
         end
         default: state_d = ST_RUN;
      endcase
   end

   // reset stretcher: extends any reset cause by the crystal cycle count
   always @* begin
      rst_busy_d = rst_busy_q;
      rst_cnt_d = rst_cnt_q;
      if (int_rst || wdog_expire) begin
         rst_busy_d = 1'b1;
         rst_cnt_d = `RST_EXTEND_CYC;
      end else if (rst_cnt_q != {`RST_CNT_W{1'b0}}) begin
         rst_cnt_d = rst_cnt_q - 1'b1;
      end else begin
         rst_busy_d = 1'b0;
      end
   end

   always @(posedge clk_sys) begin
      rst_busy_q <= rst_busy_d;
      rst_cnt_q <= rst_cnt_d;
   end

   // watchdog and wake-arm next values
   always @* begin
      wake_armed_d = wake_armed_q;
      wdog_en_d = wdog_en_q;
      wdog_halt_d = wdog_halt_q;
      wdog_cnt_d = wdog_cnt_q;
      if (is_stop) begin
         // only a pin set as input at stop time may wake the part
         wake_armed_d = port2_direction_reg[`WAKE_PIN_BIT];
      end
      if (is_refresh) begin
         wdog_en_d = 1'b1;
         wdog_cnt_d = {`WDOG_CNT_W{1'b0}};
      end else if (wdog_tick) begin
         wdog_cnt_d = wdog_cnt_q + 1'b1;
      end
      if (is_in_sleep && wdog_en_q) begin
         wdog_halt_d = 1'b1;
      end
   end

   always @(posedge clk_sys) begin
      if (rst_busy_q || int_rst) begin
         state_q <= ST_RUN;
         wake_armed_q <= 1'b0;
         wdog_en_q <= 1'b0;
         wdog_halt_q <= 1'b0;
         wdog_cnt_q <= {`WDOG_CNT_W{1'b0}};
      end else begin
         state_q <= state_d;
         wake_armed_q <= wake_armed_d;
         wdog_en_q <= wdog_en_d;
         wdog_halt_q <= wdog_halt_d;
         wdog_cnt_q <= wdog_cnt_d;
      end
   end

   // next values of the registered outputs
   always @* begin
      cpu_clk_en_d = state_nx == ST_RUN;
      osc_en_d = state_nx != ST_STOP;
      periph_clk_en_d = state_nx != ST_STOP;
      irq_pending_d = any_irq;
      halted_d = state_nx == ST_HALT;
      stopped_d = state_nx == ST_STOP;
      sys_reset_d = in_reset || wdog_expire;
      keep_port_modes_d = pin_wake && !in_reset;
      pc_load_d = pin_wake && !in_reset;
      pc_load_addr_d = `STOP_RESUME_ADDR;
      flag_wr_d = is_refresh && !in_reset;
      flag_mask_d = (8'h01 << `FLAG_Z) | (8'h01 << `FLAG_S) | (8'h01 << `FLAG_V);
      flag_val_d = 8'h01 << `FLAG_Z;
      load_refused_d = rom_protect && (code_mem_load_op || code_mem_load_autoinc_op);
      // the enabling refresh shows at once; any reset cause drops it
      wdog_enabled_d = (wdog_en_q || is_refresh) && !in_reset && !wdog_expire;
   end

   always @(posedge clk_sys) begin
      if (!rstn) begin
         cpu_clk_en <= 1'b1;
         osc_en <= 1'b1;
         periph_clk_en <= 1'b1;
         irq_pending <= 1'b0;
         halted <= 1'b0;
         stopped <= 1'b0;
         sys_reset <= 1'b1;
         keep_port_modes <= 1'b0;
         pc_load <= 1'b0;
         pc_load_addr <= 16'h0000;
         flag_wr <= 1'b0;
         flag_mask <= 8'h00;
         flag_val <= 8'h00;
         load_refused <= 1'b0;
         wdog_enabled <= 1'b0;
      end else begin
         cpu_clk_en <= cpu_clk_en_d;
         osc_en <= osc_en_d;
         periph_clk_en <= periph_clk_en_d;
         irq_pending <= irq_pending_d;
         halted <= halted_d;
         stopped <= stopped_d;
         sys_reset <= sys_reset_d;
         keep_port_modes <= keep_port_modes_d;
         pc_load <= pc_load_d;
         pc_load_addr <= pc_load_addr_d;
         flag_wr <= flag_wr_d;
         flag_mask <= flag_mask_d;
         flag_val <= flag_val_d;
         load_refused <= load_refused_d;
         wdog_enabled <= wdog_enabled_d;
      end
   end

endmodule // sleep_watchdog_ctrl

// file: rtl/sleep_wdog_map.vh
/*
 constants for the sleep-mode and watchdog controller: opcodes, vectors, counts.
 assumes clk_sys at 50 MHz stands for the crystal clock.
*/
`ifndef SLEEP_WDOG_MAP_VH
`define SLEEP_WDOG_MAP_VH
`define OP_NOP 8'hFF
`define OP_STOP 8'h6F
`define OP_HALT 8'h7F
`define OP_WDOG_REFRESH 8'h5F
`define OP_WDOG_IN_SLEEP 8'h4F
`define STOP_RESUME_ADDR 16'h000C
`define WAKE_PIN_BIT 7
`define IRQ_SRC_N 6
`define WDOG_CNT_W 24
`define WDOG_TIMEOUT_CYC 24'h0FFFFF
`define RST_EXTEND_CYC 5'h12
`define RST_CNT_W 5
`define FLAG_Z 6
`define FLAG_S 5
`define FLAG_V 4
`endif

// file: tb/cpu_decoder_model.sv
/* decoder stand-in: replays bench opcodes, services interrupts in halt
 assumes requests change just after clk_sys rises */
`timescale 1ns/10ps
module cpu_decoder_model (
   input wire clk_sys, go, halted, irq_pending,
   input wire [7:0] code,
   output reg op_valid = 0, irq_taken = 0,
   output reg [7:0] op_code = 8'h00
);
   always @(posedge clk_sys) begin
      op_valid <= #1 go;
      // idle bus shows the inverse, never a stale opcode
      op_code <= #1 go ? code : ~code;
      irq_taken <= #1 halted && irq_pending && !irq_taken;
   end
endmodule // cpu_decoder_model

// file: tb/sleep_wdog_asserts.sv
/* port assertions for the sleep/watchdog controller
 assumes one clock, rstn sync active low */
`timescale 1ns/10ps
module sleep_wdog_asserts #(parameter [23:0] WDOG_TIMEOUT = 24'h40) (
   input wire clk_sys, rstn, op_valid, code_mem_load_op, code_mem_load_autoinc_op, rom_protect, irq_taken,
   input wire cpu_clk_en, osc_en, halted, stopped, sys_reset, keep_port_modes,
   input wire pc_load, flag_wr, load_refused, wdog_enabled,
   input wire [7:0] op_code, flag_mask, flag_val,
   input wire [15:0] pc_load_addr
);
   wire run = !sys_reset && !halted && !stopped;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   halt_gates_clk_a: assert property (run && op_valid && op_code == 8'h7F |=> halted && !cpu_clk_en && osc_en)
      else $error("halt entry");
   halt_exit_a: assert property (halted && irq_taken |=> !halted && cpu_clk_en)
      else $error("halt exit");
   stop_kills_osc_a: assert property (run && op_valid && op_code == 8'h6F |=> stopped && !osc_en && !cpu_clk_en)
      else $error("stop entry");
   pin_wake_a: assert property ($fell(stopped) && !sys_reset |-> pc_load && keep_port_modes && pc_load_addr == 16'h000C)
      else $error("pin wake");
   refresh_flags_a: assert property (run && op_valid && op_code == 8'h5F |=> flag_wr && flag_mask == 8'h70 && flag_val[6:4] == 3'h4 && wdog_enabled)
      else $error("refresh");
   reset_wdog_off_a: assert property (sys_reset |=> !wdog_enabled)
      else $error("wdog on in reset");
   rom_refuse_a: assert property (rom_protect && (code_mem_load_op || code_mem_load_autoinc_op) |=> load_refused)
      else $error("load not refused");
   reset_len_a: assert property ($rose(sys_reset) |-> sys_reset[*8] ##1 sys_reset[*8] ##1 sys_reset[*2])
      else $error("reset too short");
   cover property ($rose(halted));
   cover property ($fell(stopped));
   cover property ($rose(sys_reset));
endmodule // sleep_wdog_asserts
bind sleep_watchdog_ctrl sleep_wdog_asserts #(.WDOG_TIMEOUT(WDOG_TIMEOUT)) chk (.*);

// file: tb/test_sleep_watchdog_ctrl.sv
/* bench for sleep_watchdog_ctrl, decoder model on its op side
 assumes the map header is on the include path */
`timescale 1ns/10ps
`include "sleep_wdog_map.vh"
module test_sleep_watchdog_ctrl;
   logic clk_sys = 0, rstn = 0, go = 0, rom_protect = 0, stop_wake_pin = 1, low_supply_trip_level = 0;
   logic code_mem_load_op = 0, code_mem_load_autoinc_op = 0;
   logic [7:0] code = 0, port2_direction_reg = 8'h80;
   logic [5:0] src = 0;
   logic op_valid, irq_taken, cpu_clk_en, osc_en, periph_clk_en, irq_pending, halted, stopped, sys_reset;
   logic keep_port_modes, pc_load, flag_wr, load_refused, wdog_enabled;
   logic [7:0] op_code, flag_mask, flag_val;
   logic [15:0] pc_load_addr;
   int mismatches = 0, cmp_count = 0, n;
   always #10 clk_sys = ~clk_sys;
   cpu_decoder_model cpu (.*);
   sleep_watchdog_ctrl #(.WDOG_TIMEOUT(24'h40)) uut (.*, .ext_irq_a(src[0]), .ext_irq_b(src[1]),
      .ext_irq_c(src[2]), .ext_irq_d(src[3]), .timer_irq_0(src[4]), .timer_irq_1(src[5]));
   task check(input [31:0] seen, input [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task complete_run;
      $display("mismatches %0d compares %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic wait_on(ref logic s, input logic v, input int lim);
      n = 0;
      while (s !== v) begin
         @(posedge clk_sys) #1 n++;
         if (n > lim) begin
            mismatches++;
            complete_run;
         end
      end
   endtask
   task issue(input [7:0] c, input nop);
      go = 1;
      code = nop ? `OP_NOP : c;
      if (nop) @(posedge clk_sys) #1 code = c;
      @(posedge clk_sys) #1 go = 0;
      @(posedge clk_sys) #1;
   endtask
   initial begin
      repeat (5) @(posedge clk_sys);
      #1 rstn = 1;
      wait_on(sys_reset, 0, 40);
      check(wdog_enabled, 0);
      for (int i = 0; i < 4; i++) begin
         rom_protect = i[0];
         {code_mem_load_autoinc_op, code_mem_load_op} = i[1] ? 2'b10 : 2'b01;
         @(posedge clk_sys) #1 check(load_refused, i[0]);
      end
      {code_mem_load_autoinc_op, code_mem_load_op} = 2'b00;
      for (int j = 0; j < 6; j++) begin
         issue(`OP_HALT, 1);
         check({halted, cpu_clk_en, osc_en, periph_clk_en}, 4'b1011);
         src[j] = 1;
         wait_on(halted, 0, 8);
         check(cpu_clk_en, 1);
         src[j] = 0;
      end
      issue(`OP_WDOG_REFRESH, 0);
      check({wdog_enabled, flag_wr, flag_mask, flag_val[6:4]}, {2'b11, 8'h70, 3'h4});
      repeat (4) begin
         repeat (40) @(posedge clk_sys);
         #1 issue(`OP_WDOG_REFRESH, 0);
      end
      check(sys_reset, 0);
      issue(`OP_HALT, 1);
      repeat (150) @(posedge clk_sys);
      #1 check(sys_reset, 0);
      src[1] = 1;
      wait_on(halted, 0, 8);
      src[1] = 0;
      issue(`OP_WDOG_REFRESH, 0);
      issue(`OP_STOP, 1);
      check({stopped, osc_en, cpu_clk_en, periph_clk_en}, 4'b1000);
      repeat (150) @(posedge clk_sys);
      #1 check(sys_reset, 0);
      stop_wake_pin = 0;
      wait_on(stopped, 0, 8);
      check({pc_load, keep_port_modes, pc_load_addr}, {2'b11, 16'h000C});
      stop_wake_pin = 1;
      issue(`OP_WDOG_REFRESH, 0);
      issue(`OP_WDOG_IN_SLEEP, 0);
      issue(`OP_HALT, 1);
      wait_on(sys_reset, 1, 80);
      wait_on(sys_reset, 0, 40);
      check(n >= 18, 1);
      check(wdog_enabled, 0);
      low_supply_trip_level = 1;
      repeat (3) @(posedge clk_sys);
      #1 check(sys_reset, 1);
      low_supply_trip_level = 0;
      wait_on(sys_reset, 0, 40);
      port2_direction_reg = 8'h00;
      issue(`OP_STOP, 1);
      stop_wake_pin = 0;
      repeat (4) @(posedge clk_sys);
      #1 check({stopped, pc_load}, 2'b10);
      stop_wake_pin = 1;
      rstn = 0;
      repeat (2) @(posedge clk_sys);
      #1 rstn = 1;
      wait_on(sys_reset, 0, 40);
      check({stopped, wdog_enabled, cpu_clk_en}, 3'b001);
      complete_run;
   end
endmodule // test_sleep_watchdog_ctrl
